// ### hw/odsc_top.sv
// Downstream subcarrier configuration, checking, lookup and symbol framing
`timescale 1ns/10ps
`default_nettype none
module odsc_top
    import odsc_pkg::*;
#(
    parameter int SC_COUNT = `ODSC_SC_COUNT,
    parameter int IDX_W = `ODSC_IDX_W,
    parameter int SPT = `ODSC_SAMPLES_PER_TICK
) (
    input wire logic clk, // System clock, 20 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic masterTick, // Master clock tick pulse
    input wire logic [3:0] cpMult, // Prefix length in sixty-fourths
    input wire logic cfgWrEn, // Write one shadow code
    input wire logic [IDX_W-1:0] cfgWrIdx, // Subcarrier index to write
    input wire logic [3:0] cfgWrCode, // Type code to write
    input wire logic cfgCommit, // Check shadow table and arm swap
    input wire logic [IDX_W-1:0] linkLow, // Lowest link-channel subcarrier
    input wire logic [IDX_W-1:0] linkHigh, // Highest link-channel subcarrier
    input wire logic qryValid, // Descriptor lookup request
    input wire logic [IDX_W-1:0] qryIdx, // Subcarrier index looked up
    output logic ansValid, // Descriptor answer strobe
    output odsc_pkg::odsc_desc_t ans, // Descriptor answer
    output odsc_pkg::odsc_timing_t timing, // Symbol and frame marks
    output logic [12:0] symLen, // Symbol length in samples
    output logic timingFault, // Symbol shorter than FFT time
    output logic cfgBusy, // Checking or swap pending
    output logic cfgWrRefused, // Write or commit refused while busy
    output logic cfgPending, // Checked table waits for frame start
    output logic cfgBank, // Active table bank
    output logic cfgOk, // Last check passed
    output odsc_pkg::odsc_check_t cfgCheck // Fault flags of last check
);
    import odsc_pkg::*;

    generate
        if (SC_COUNT != (1 << IDX_W) || SC_COUNT < 2 * `ODSC_PILOT_SPACING) begin : gBad
            $error("odsc_top: subcarrier count and index width disagree");
        end
    endgenerate

    localparam logic [IDX_W:0] LAST_IDX = (IDX_W+1)'(SC_COUNT - 1);
    localparam logic [12:0] MIN_GROUP = 13'(`ODSC_MIN_GROUP);
    localparam logic [12:0] MIN_BAND = 13'(`ODSC_MIN_BAND_SC);
    localparam logic [12:0] GUARD = 13'(`ODSC_GUARD_SC);
    localparam logic [12:0] TOP_OK = 13'(SC_COUNT - 1 - `ODSC_GUARD_SC);
    localparam logic [12:0] MAX_BANDS = 13'(`ODSC_MAX_INT_BANDS);
    localparam logic [15:0] EXCL_DIV = 16'(100 / `ODSC_MAX_EXCL_PCT);

    typedef enum {CK_IDLE, CK_SCAN, CK_TAIL, CK_EVAL} odsc_ck_state_t;
    odsc_ck_state_t ckState;

    // Memory ports
    logic memWrEn;
    logic [IDX_W:0] memWrAddr;
    logic [IDX_W:0] memRdAddrA;
    logic [IDX_W:0] memRdAddrB;
    logic [3:0] rdDataA;
    logic [3:0] rdDataB;
    odsc_check_t nextCheck;

    odsc_sym_timer #(
        .SPT(SPT),
        .FFT_LEN(`ODSC_FFT_SAMPLES),
        .MIN_SYM_CLK(`ODSC_FFT_CLK)
    ) uTimer (
        .clk(clk),
        .rst_n(rst_n),
        .masterTick(masterTick),
        .cpMult(cpMult),
        .timing(timing),
        .symLen(symLen),
        .timingFault(timingFault)
    );

    odsc_cfg_mem #(
        .W(`ODSC_CODE_W),
        .AW(IDX_W + 1)
    ) uMem (
        .clk(clk),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(cfgWrCode),
        .rdAddrA(memRdAddrA),
        .rdDataA(rdDataA),
        .rdAddrB(memRdAddrB),
        .rdDataB(rdDataB)
    );

    // Shadow bank is frozen once checked, so the swapped table is the checked one
    assign cfgBusy = (ckState != CK_IDLE) || cfgPending;
    assign cfgWrRefused = (cfgWrEn || cfgCommit) && cfgBusy;
    assign memWrEn = cfgWrEn && !cfgBusy;
    assign memWrAddr = {~cfgBank, cfgWrIdx};

    // Bank swap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgBank <= 1'b0;
            cfgPending <= 1'b0;
        end else if (timing.frameStart && cfgPending) begin
            cfgBank <= ~cfgBank;
            cfgPending <= 1'b0;
        end else if (ckState == CK_EVAL && cfgCheck == '0 && nextCheck == '0) begin
            cfgPending <= 1'b1;
        end
    end

    // Check scan over the shadow table
    logic [IDX_W:0] scanIdx;
    logic chkValid;
    logic [IDX_W-1:0] chkIdx;
    odsc_class_t chkClass;

    assign memRdAddrB = {~cfgBank, scanIdx[IDX_W-1:0]};
    assign chkClass = odscClassOf(rdDataB);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ckState <= CK_IDLE;
            scanIdx <= '0;
        end else begin
            case (ckState)
                CK_IDLE: begin
                    if (cfgCommit && !cfgPending) begin
                        ckState <= CK_SCAN;
                        scanIdx <= '0;
                    end
                end
                CK_SCAN: begin
                    if (scanIdx == LAST_IDX) begin
                        ckState <= CK_TAIL;
                    end else begin
                        scanIdx <= scanIdx + 1'b1;
                    end
                end
                CK_TAIL: begin
                    ckState <= CK_EVAL;
                end
                CK_EVAL: begin
                    ckState <= CK_IDLE;
                end
                default: begin
                    ckState <= CK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chkValid <= 1'b0;
            chkIdx <= '0;
        end else begin
            chkValid <= (ckState == CK_SCAN);
            chkIdx <= scanIdx[IDX_W-1:0];
        end
    end

    // Run trackers
    logic seenAct, prevExcl, wideSeen, groupShort;
    logic [12:0] firstAct, lastAct, actRun, loadRun;
    logic [12:0] exclRuns, exclTotal, exclRunCur;
    logic isAct, isLoaded, startScan;

    assign isAct = (chkClass != SC_EXCLUDED);
    assign isLoaded = (chkClass == SC_DATA) || (chkClass == SC_CPILOT);
    assign startScan = (ckState == CK_IDLE) && cfgCommit && !cfgPending;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seenAct <= 1'b0;
            firstAct <= '0;
            lastAct <= '0;
        end else if (startScan) begin
            seenAct <= 1'b0;
            firstAct <= '0;
            lastAct <= '0;
        end else if (chkValid && isAct) begin
            if (!seenAct) begin
                firstAct <= 13'(chkIdx);
            end
            seenAct <= 1'b1;
            lastAct <= 13'(chkIdx);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            actRun <= '0;
            groupShort <= 1'b0;
            prevExcl <= 1'b0;
        end else if (startScan) begin
            actRun <= '0;
            groupShort <= 1'b0;
            prevExcl <= 1'b0;
        end else if (chkValid) begin
            prevExcl <= !isAct;
            if (isAct) begin
                actRun <= actRun + 13'h0001;
            end else begin
                actRun <= '0;
                if (seenAct && !prevExcl && actRun < MIN_GROUP) begin
                    groupShort <= 1'b1;
                end
            end
        end
    end

    // Loaded band may hold pilots and link subcarriers; nulls and exclusions end it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loadRun <= '0;
            wideSeen <= 1'b0;
        end else if (startScan) begin
            loadRun <= '0;
            wideSeen <= 1'b0;
        end else if (chkValid) begin
            if (isLoaded) begin
                loadRun <= loadRun + 13'h0001;
                if (loadRun + 13'h0001 >= MIN_BAND) begin
                    wideSeen <= 1'b1;
                end
            end else begin
                loadRun <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exclRuns <= '0;
            exclTotal <= '0;
            exclRunCur <= '0;
        end else if (startScan) begin
            exclRuns <= '0;
            exclTotal <= '0;
            exclRunCur <= '0;
        end else if (chkValid) begin
            if (isAct) begin
                exclRunCur <= '0;
            end else if (seenAct) begin
                exclTotal <= exclTotal + 13'h0001;
                exclRunCur <= exclRunCur + 13'h0001;
                if (!prevExcl) begin
                    exclRuns <= exclRuns + 13'h0001;
                end
            end
        end
    end

    // Final judgement; a trailing exclusion run is the upper band edge, not internal
    logic [12:0] innerBands, innerExcl, span;

    always_comb begin
        innerBands = exclRuns - 13'((seenAct && prevExcl) ? 1 : 0);
        innerExcl = exclTotal - (prevExcl ? exclRunCur : 13'h0000);
        span = lastAct - firstAct + 13'h0001;
        nextCheck = '0;
        nextCheck.groupShort = groupShort || (seenAct && !prevExcl && actRun < MIN_GROUP);
        nextCheck.guardShort = !seenAct || firstAct < GUARD || lastAct > TOP_OK;
        nextCheck.exclWide = 16'(innerExcl) * EXCL_DIV > 16'(span);
        nextCheck.noWideBand = !wideSeen;
        nextCheck.manyBands = innerBands > MAX_BANDS;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgCheck <= '0;
            cfgOk <= 1'b0;
        end else if (startScan) begin
            cfgCheck <= '0;
        end else if (ckState == CK_EVAL) begin
            cfgCheck <= nextCheck;
            cfgOk <= (nextCheck == '0);
        end
    end

    // Lookup pipeline over the active table
    logic q1Valid;
    logic [IDX_W-1:0] q1Idx;
    logic [6:0] q1Sym;
    odsc_desc_t nextAns;
    odsc_class_t q1Class;
    logic [6:0] dataSym;
    logic [IDX_W-1:0] pilotOffs;
    logic inLink, spPos;

    assign memRdAddrA = {cfgBank, qryIdx};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q1Valid <= 1'b0;
            q1Idx <= '0;
            q1Sym <= '0;
        end else begin
            q1Valid <= qryValid;
            q1Idx <= qryIdx;
            q1Sym <= timing.symIndex;
        end
    end

    // Pattern anchored just above the link band on the first symbol after preamble
    always_comb begin
        q1Class = odscClassOf(rdDataA);
        dataSym = q1Sym - 7'(`ODSC_PREAMBLE_SYMS);
        pilotOffs = q1Idx - linkHigh - IDX_W'(1) - IDX_W'(dataSym);
        spPos = (pilotOffs[6:0] == 7'h00);
        inLink = (q1Idx >= linkLow) && (q1Idx <= linkHigh);
        nextAns = '0;
        nextAns.index = 12'(q1Idx);
        nextAns.code = rdDataA;
        nextAns.bitsPerSym = 4'h0;
        case (q1Class)
            SC_EXCLUDED: begin
                nextAns.kind = TX_ZERO;
            end
            SC_CPILOT: begin
                nextAns.kind = TX_CPILOT;
                nextAns.bitsPerSym = odscBitsOf(rdDataA);
            end
            SC_NULL: begin
                nextAns.kind = (spPos && !inLink) ? TX_SPILOT : TX_NULL;
            end
            SC_DATA: begin
                if (inLink) begin
                    nextAns.kind = TX_LINK;
                    nextAns.bitsPerSym = odscBitsOf(rdDataA);
                end else if (spPos) begin
                    nextAns.kind = TX_SPILOT;
                end else begin
                    nextAns.kind = TX_DATA;
                    nextAns.bitsPerSym = odscBitsOf(rdDataA);
                end
            end
            default: begin
                nextAns.kind = TX_ZERO;
            end
        endcase
        nextAns.zeroAmp = (nextAns.kind == TX_ZERO);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ansValid <= 1'b0;
            ans <= '0;
        end else begin
            ansValid <= q1Valid;
            if (q1Valid) begin
                ans <= nextAns;
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/odsc_map.svh
// Constants for the downstream subcarrier configuration and symbol timing block
// Functional notes
// - Symbol timing derived from, locked to master clock
// - FFT part of each symbol lasts 20 us
// - Subcarrier clock is master times 40 over 8192
// - Whole subcarrier cycles in each FFT period
// - Prefix is whole sixty-fourths of FFT period
// - Symbol holds K plus K*L/64 subcarrier cycles
// - Equal points share phase; repeats every 64 symbols
// - One 4-bit code per subcarrier, 4096 entries
// - Codes 1111..1100: excluded, 16384/8192/4096-QAM
// - Codes 1011..0010: 2048-QAM down to QPSK
// - 0001 continuous pilot only; 0000 null
// - Null carries no data unless scattered pilot
// - Excluded subcarriers get zero amplitude
// - Data subcarriers use their assigned modulation
// - Head end shares one configuration with subscribers
// - Groups >=40, guard >=1 MHz, exclusion <=20%
// - Need one loaded band of 22 MHz
// - Accept up to 14 internal exclusion bands
// - Frames of 128 symbols, aligned to link frame
// - First 8 frame symbols are link preamble
// - Timestamp marks first symbol after preamble
// - Scattered pilot every 128, shifting one per symbol
`ifndef ODSC_MAP_SVH
`define ODSC_MAP_SVH
`define ODSC_SC_COUNT 4096
`define ODSC_IDX_W 12
`define ODSC_CODE_W 4
`define ODSC_MASTER_KHZ 10240
`define ODSC_SAMPLE_KHZ 204800
`define ODSC_SC_NUM 40
`define ODSC_SC_DEN 8192
`define ODSC_SAMPLES_PER_TICK (`ODSC_SAMPLE_KHZ / `ODSC_MASTER_KHZ)
`define ODSC_FFT_SAMPLES ((`ODSC_SAMPLE_KHZ * `ODSC_SC_DEN) / (`ODSC_MASTER_KHZ * `ODSC_SC_NUM))
`define ODSC_CP_UNIT 64
`define ODSC_FFT_NS 20000
`define ODSC_CLK_NS 50
`define ODSC_FFT_CLK ((`ODSC_FFT_NS + `ODSC_CLK_NS - 1) / `ODSC_CLK_NS)
`define ODSC_FRAME_SYMS 128
`define ODSC_PREAMBLE_SYMS 8
`define ODSC_PHASE_CYCLE 64
`define ODSC_PILOT_SPACING 128
`define ODSC_SC_SPACING_KHZ 50
`define ODSC_GUARD_KHZ 1000
`define ODSC_GUARD_SC (`ODSC_GUARD_KHZ / `ODSC_SC_SPACING_KHZ)
`define ODSC_MIN_BAND_KHZ 22000
`define ODSC_MIN_BAND_SC (`ODSC_MIN_BAND_KHZ / `ODSC_SC_SPACING_KHZ)
`define ODSC_MIN_GROUP 40
`define ODSC_MAX_INT_BANDS 14
`define ODSC_MAX_EXCL_PCT 20
`define ODSC_CODE_EXCL 4'hf
`define ODSC_CODE_BPSK 4'h1
`define ODSC_CODE_NULL 4'h0
`endif

// ### hw/odsc_pkg.sv
// Types and code decoding shared by the subcarrier configuration block
`include "odsc_map.svh"
package odsc_pkg;
    typedef enum logic [1:0] {SC_EXCLUDED, SC_NULL, SC_CPILOT, SC_DATA} odsc_class_t;
    typedef enum logic [2:0] {TX_ZERO, TX_NULL, TX_CPILOT, TX_SPILOT, TX_LINK, TX_DATA} odsc_tx_t;
    typedef struct packed {
        logic symStart;
        logic frameStart;
        logic preamble;
        logic timestamp;
        logic phaseCycleStart;
        logic [6:0] symIndex;
    } odsc_timing_t;
    typedef struct packed {
        logic [11:0] index;
        logic [3:0] code;
        odsc_tx_t kind;
        logic [3:0] bitsPerSym;
        logic zeroAmp;
    } odsc_desc_t;
    typedef struct packed {
        logic groupShort;
        logic guardShort;
        logic exclWide;
        logic noWideBand;
        logic manyBands;
    } odsc_check_t;

    function automatic odsc_class_t odscClassOf(input logic [3:0] code);
        if (code == `ODSC_CODE_EXCL) begin
            return SC_EXCLUDED;
        end else if (code == `ODSC_CODE_NULL) begin
            return SC_NULL;
        end else if (code == `ODSC_CODE_BPSK) begin
            return SC_CPILOT;
        end
        return SC_DATA;
    endfunction

    // QAM order is two to the code value, so bits per symbol equal the code
    function automatic logic [3:0] odscBitsOf(input logic [3:0] code);
        if (code == `ODSC_CODE_EXCL || code == `ODSC_CODE_NULL) begin
            return 4'h0;
        end
        return code;
    endfunction
endpackage

// ### hw/odsc_cfg_mem.sv
// Two-bank table of subcarrier type codes, one write and two registered reads
`timescale 1ns/10ps
`default_nettype none
module odsc_cfg_mem #(
    parameter int W = 4,
    parameter int AW = 13
) (
    input wire logic clk, // System clock
    input wire logic wrEn, // Write strobe
    input wire logic [AW-1:0] wrAddr, // Write address, bank in top bit
    input wire logic [W-1:0] wrData, // Write data
    input wire logic [AW-1:0] rdAddrA, // Query read address
    output logic [W-1:0] rdDataA, // Query read data, one cycle later
    input wire logic [AW-1:0] rdAddrB, // Check read address
    output logic [W-1:0] rdDataB // Check read data, one cycle later
);
    generate
        if (W < 1 || AW < 2) begin : gBad
            $error("odsc_cfg_mem: unusable width or depth");
        end
    endgenerate

    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end
endmodule
`default_nettype wire

// ### hw/odsc_sym_timer.sv
// Symbol and frame timing counted in sample units from master clock ticks
`timescale 1ns/10ps
`default_nettype none
module odsc_sym_timer
    import odsc_pkg::*;
#(
    parameter int SPT = `ODSC_SAMPLES_PER_TICK,
    parameter int FFT_LEN = `ODSC_FFT_SAMPLES,
    parameter int MIN_SYM_CLK = `ODSC_FFT_CLK
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic masterTick, // One pulse per master clock cycle
    input wire logic [3:0] cpMult, // Prefix length in sixty-fourths
    output odsc_pkg::odsc_timing_t timing, // Symbol and frame marks
    output logic [12:0] symLen, // Current symbol length in samples
    output logic timingFault // Last symbol shorter than FFT time
);
    generate
        if (SPT < 1 || FFT_LEN % `ODSC_CP_UNIT != 0 || FFT_LEN + 15 * `ODSC_CP_UNIT >= 8192
            || MIN_SYM_CLK < 1 || MIN_SYM_CLK > 65535 || `ODSC_FRAME_SYMS != 128) begin : gBad
            $error("odsc_sym_timer: parameters out of range");
        end
    endgenerate

    localparam logic [12:0] SPT_V = 13'(SPT);
    localparam logic [12:0] FFT_V = 13'(FFT_LEN);
    localparam logic [12:0] CP_V = 13'(`ODSC_CP_UNIT);
    localparam logic [15:0] MIN_V = 16'(MIN_SYM_CLK);

    logic [12:0] acc;
    logic [12:0] sum;
    logic [12:0] next_symLen;
    logic symEnd;
    logic [6:0] symIndex;
    logic [6:0] next_symIndex;
    logic [5:0] phaseCnt;
    logic [15:0] gapCnt;
    logic symStart, frameStart, preamble, stampMark, phaseStart;

    assign sum = acc + SPT_V;
    assign next_symLen = FFT_V + 13'(cpMult) * CP_V;
    assign symEnd = masterTick && (sum >= symLen);
    assign next_symIndex = symIndex + 7'h01;

    // Remainder carries over so timing never drifts from the master clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 13'h0000;
        end else if (symEnd) begin
            acc <= sum - symLen;
        end else if (masterTick) begin
            acc <= sum;
        end
    end

    // Whole FFT length plus whole prefix units, so every subcarrier closes its cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            symLen <= FFT_V;
        end else if (symEnd) begin
            symLen <= next_symLen;
        end
    end

    // Index starts at the last symbol so the first boundary opens a frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            symIndex <= 7'h7f;
            phaseCnt <= 6'h3f;
        end else if (symEnd) begin
            symIndex <= next_symIndex;
            phaseCnt <= phaseCnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            symStart <= 1'b0;
            frameStart <= 1'b0;
            stampMark <= 1'b0;
            phaseStart <= 1'b0;
        end else begin
            symStart <= symEnd;
            frameStart <= symEnd && (symIndex == 7'h7f);
            stampMark <= symEnd && (next_symIndex == 7'(`ODSC_PREAMBLE_SYMS));
            phaseStart <= symEnd && (phaseCnt == 6'h3f);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preamble <= 1'b0;
        end else if (symEnd) begin
            preamble <= next_symIndex < 7'(`ODSC_PREAMBLE_SYMS);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gapCnt <= 16'h0000;
            timingFault <= 1'b0;
        end else if (symEnd) begin
            gapCnt <= 16'h0000;
            timingFault <= (gapCnt + 16'h0001) < MIN_V;
        end else if (gapCnt < MIN_V) begin
            gapCnt <= gapCnt + 16'h0001;
        end
    end

    assign timing = '{symStart, frameStart, preamble, stampMark, phaseStart, symIndex};
endmodule
`default_nettype wire

// ### sim/odsc_assertions.sv
// Port checker for the subcarrier configuration block
`timescale 1ns/10ps
`default_nettype none
module odsc_assertions #(
    parameter int IDX_W = 12
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic qryValid, // Lookup request
    input wire logic [IDX_W-1:0] qryIdx, // Lookup index
    input wire logic ansValid, // Answer strobe
    input wire odsc_pkg::odsc_desc_t ans, // Answer
    input wire odsc_pkg::odsc_timing_t timing, // Symbol marks
    input wire logic cfgPending, // Swap armed
    input wire logic cfgBank // Active bank
);
    import odsc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence frameHead;
        timing.symStart && timing.preamble && timing.symIndex == 7'h0;
    endsequence
    sequence swapEdge;
        timing.frameStart && cfgPending;
    endsequence
    chk_ans_latency: assert property (
        qryValid |-> ##2 ansValid) else $error("late answer");
    chk_ans_index: assert property (
        ansValid |-> ans.index == $past(qryIdx, 2)) else $error("bad index");
    chk_excl_zero: assert property (
        ansValid && ans.code == 4'hf |-> ans.zeroAmp && ans.kind == TX_ZERO) else $error("excl");
    chk_null_quiet: assert property (
        ansValid && ans.code == 4'h0 |-> ans.bitsPerSym == 4'h0 && ans.kind != TX_DATA)
        else $error("null loaded");
    chk_data_bits: assert property (
        ansValid && ans.kind == TX_DATA |-> ans.bitsPerSym == ans.code) else $error("bits");
    chk_frame_head: assert property (
        timing.frameStart |-> frameHead) else $error("frame head");
    chk_sym_step: assert property (
        timing.symStart |-> timing.symIndex == $past(timing.symIndex) + 7'h1)
        else $error("symbol step");
    chk_stamp_pos: assert property (
        timing.timestamp |-> timing.symStart && timing.symIndex == 7'h8) else $error("stamp");
    chk_phase_cycle: assert property (
        timing.phaseCycleStart |-> timing.symIndex[5:0] == 6'h0) else $error("phase");
    chk_bank_swap: assert property (
        swapEdge |=> cfgBank != $past(cfgBank) && !cfgPending) else $error("swap");
endmodule
bind odsc_top odsc_assertions #(.IDX_W(IDX_W)) u_odsc_assertions (.clk, .rst_n, .qryValid,
    .qryIdx, .ansValid, .ans, .timing, .cfgPending, .cfgBank);
`default_nettype wire

// ### sim/odsc_sub_node.sv
// Subscriber-side model that locks onto the downstream frame marks
`timescale 1ns/10ps
`default_nettype none
module odsc_sub_node (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire odsc_pkg::odsc_timing_t timing, // Received marks
    output logic locked, // Frame lock held
    output logic [7:0] slips // Frames that broke alignment
);
    import odsc_pkg::*;
    logic [6:0] symCnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locked <= 1'b0;
            slips <= 8'h0;
            symCnt <= 7'h0;
        end else if (timing.symStart && timing.frameStart) begin
            if (locked && symCnt != 7'h7f) begin
                slips <= slips + 8'h1;
            end
            locked <= 1'b1;
            symCnt <= 7'h0;
        end else if (timing.symStart) begin
            symCnt <= symCnt + 7'h1;
        end
    end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the subcarrier configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import odsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic masterTick = 1'b0, cfgWrEn = 1'b0, cfgCommit = 1'b0, qryValid = 1'b0;
    logic [3:0] cpMult = 4'h0, cfgWrCode = 4'h0;
    logic [11:0] cfgWrIdx = 12'h0, linkLow = 12'h3e8, linkHigh = 12'h3ef, qryIdx = 12'h0;
    logic ansValid, timingFault, cfgBusy, cfgWrRefused, cfgPending, cfgBank, cfgOk, locked;
    logic [12:0] symLen;
    logic [7:0] slips;
    odsc_desc_t ans;
    odsc_timing_t timing;
    odsc_check_t cfgCheck;
    int errorCnt = 0, testsRun = 0;
    always #25 clk = ~clk;
    // Master tick about every second clock, as 10.24 MHz against 20 MHz
    always @(posedge clk) masterTick <= rst_n ? ~masterTick : 1'b0;
    odsc_top u_odsc_top (.clk, .rst_n, .masterTick, .cpMult, .cfgWrEn, .cfgWrIdx, .cfgWrCode,
        .cfgCommit, .linkLow, .linkHigh, .qryValid, .qryIdx, .ansValid, .ans, .timing, .symLen,
        .timingFault, .cfgBusy, .cfgWrRefused, .cfgPending, .cfgBank, .cfgOk, .cfgCheck);
    odsc_sub_node u_odsc_sub_node (.clk, .rst_n, .timing, .locked, .slips);
    task automatic finalReport;
        if (errorCnt == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Guard bands at both edges, one internal run holding every code
    function automatic logic [3:0] codeOf(input int i);
        if (i < 20 || i > 4075) return 4'hf;
        if (i >= 2000 && i < 2016) return 4'(i - 2000);
        return 4'h6;
    endfunction
    task automatic loadTable(input logic allExcl);
        for (int i = 0; i < 4096; i++) begin
            @(posedge clk);
            cfgWrEn <= 1'b1;
            cfgWrIdx <= 12'(i);
            cfgWrCode <= allExcl ? 4'hf : codeOf(i);
        end
        @(posedge clk);
        cfgWrEn <= 1'b0;
        cfgCommit <= 1'b1;
        @(posedge clk);
        cfgCommit <= 1'b0;
    endtask
    task automatic lookup(input int i);
        logic [3:0] c;
        logic [6:0] s;
        odsc_tx_t k;
        c = codeOf(i);
        k = c == 4'hf ? TX_ZERO : c == 4'h0 ? TX_NULL : c == 4'h1 ? TX_CPILOT : TX_DATA;
        if (i >= 1000 && i <= 1007) k = TX_LINK;
        @(posedge clk);
        qryValid <= 1'b1;
        qryIdx <= 12'(i);
        @(negedge clk);
        s = timing.symIndex;
        if (k inside {TX_NULL, TX_DATA} && 7'(i - 1000 - s) == 0) k = TX_SPILOT;
        @(posedge clk);
        qryValid <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        cmp(ansValid, 1, "answer");
        cmp(ans.kind, k, "kind");
        cmp(ans.zeroAmp, c == 4'hf, "amplitude");
        if (k != TX_LINK) cmp(ans.bitsPerSym, k == TX_DATA ? c : k == TX_CPILOT, "bits");
    endtask
    task automatic waitSym;
        @(negedge clk);
        for (int k = 0; k < 1000 && timing.symStart !== 1'b1; k++) @(negedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp(symLen, 16'd4096, "reset length");
        loadTable(1'b0);
        @(posedge clk);
        cfgWrEn <= 1'b1;
        @(negedge clk);
        cmp(cfgWrRefused, 1, "refuse");
        @(posedge clk);
        cfgWrEn <= 1'b0;
        cpMult <= 4'h4;
        for (int k = 0; k < 60000 && cfgBank !== 1'b1; k++) @(negedge clk);
        cmp({cfgBank, cfgOk, cfgCheck}, 16'h60, "commit");
        for (int i = 2000; i < 2016; i++) lookup(i);
        lookup(1003);
        lookup(5);
        repeat (2) waitSym();
        cmp(symLen, 16'd4352, "prefix length");
        cmp(timingFault, 0, "symbol time");
        loadTable(1'b1);
        for (int k = 0; k < 5000 && cfgOk !== 1'b0; k++) @(negedge clk);
        cmp({cfgBusy, cfgBank, cfgOk, cfgCheck}, 16'h4a, "bad table");
        cmp({locked, slips}, 16'h100, "subscriber lock");
        finalReport();
    end
    initial begin
        #(90000 * 50);
        errorCnt++;
        finalReport();
    end
endmodule
`default_nettype wire
